// >>> src/gdsc_cfg.svh
// Purpose: Constants for the gate DAC setpoint and calibration bank.
// Assumes: 125 MHz reference clock, 12-bit codes in 16-bit data words.
// Notes:   Calibration intervals are kept in microseconds, the clock period in nanoseconds; counts derive in code.
`ifndef GDSC_CFG_SVH
`define GDSC_CFG_SVH

// Command bytes of the write-only registers.
`define GDSC_CMD_CH1_SETPOINT   8'h40
`define GDSC_CMD_CH2_SETPOINT   8'h42
`define GDSC_CMD_CH1_PARAM      8'h44
`define GDSC_CMD_CH2_PARAM      8'h46
`define GDSC_CMD_CH1_DAC_INPUT  8'h48
`define GDSC_CMD_CH1_DAC_DIRECT 8'h4A
`define GDSC_CMD_CH2_DAC_INPUT  8'h4C
`define GDSC_CMD_CH2_DAC_DIRECT 8'h4E
`define GDSC_CMD_CAL_CTRL       8'h5E

// Field positions and widths.
`define GDSC_CODE_MSB           11
`define GDSC_CODE_W             12
`define GDSC_CAL_CH2_SHORT_BIT  4
`define GDSC_CAL_CH1_SHORT_BIT  3
`define GDSC_CAL_TRACK_BIT      2
`define GDSC_CAL_ONESHOT_BIT    1
`define GDSC_CAL_PERIODIC_BIT   0

// Parameter-source codes that route the parameter into the computation.
`define GDSC_PSRC_A             3'h2
`define GDSC_PSRC_B             3'h5
`define GDSC_PSRC_C             3'h6
`define GDSC_PSRC_D             3'h7

// Reset values.
`define GDSC_CODE_RST           12'h000
`define GDSC_CAL_RST            5'h00

// Timing.
`define GDSC_CLK_PERIOD_NS      8
`define GDSC_CAL_PERIOD_US      15000
`define GDSC_CAL_REARM_US       13000
`define GDSC_TIMER_W            21

`endif

// >>> src/gdsc_pkg.sv
// Purpose: Types shared by the gate DAC setpoint and calibration bank.
// Assumes: Constants come from gdsc_cfg.svh.
// Notes:   Structs carry the command write and the calibration fields.
package gdsc_pkg;

	// One command write: command byte plus 16-bit data word.
	typedef struct packed {
		logic        valid;
		logic [7:0]  cmd;
		logic [15:0] data;
	} gdsc_wr_t;

	// Calibration control fields, MSB first as in the data word.
	typedef struct packed {
		logic ch2_offset_short;
		logic ch1_offset_short;
		logic track;
		logic cal_oneshot;
		logic cal_periodic_en;
	} gdsc_cal_ctrl_t;

	// Calibration sequencer states.
	typedef enum logic [0:0] {
		GDSC_CAL_IDLE = 1'b0,
		GDSC_CAL_RUN  = 1'b1
	} gdsc_cal_state_t;

endpackage

// >>> src/gdsc_code_calc.sv
// Purpose: Per-channel DAC code computation with a completion strobe.
// Assumes: Start is a one-cycle pulse; inputs are stable when it is high.
// Notes:   The real transfer equation lives elsewhere; here the parameter
//          replaces the setpoint when the source field selects it.
`timescale 1ns/10ps
`include "gdsc_cfg.svh"

module gdsc_code_calc
(
	// Clock and reset.
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// Request.
	input  wire logic        i_start,
	input  wire logic [11:0] i_setpoint,
	input  wire logic [11:0] i_param,
	input  wire logic [2:0]  i_param_source_sel,
	// Result.
	output logic      [11:0] o_code,
	output logic             o_done
);

	logic [11:0] code_reg;   // Last computed code.
	logic [11:0] code_next;  // Next computed code.
	logic        done_reg;   // Completion strobe.
	logic        done_next;  // Next completion strobe.
	logic        use_param;  // Parameter selected as the input value.

	// Choose the value and raise the strobe one cycle after the start.
	always_comb
	begin
		use_param = (i_param_source_sel == `GDSC_PSRC_A) ||
			(i_param_source_sel == `GDSC_PSRC_B) ||
			(i_param_source_sel == `GDSC_PSRC_C) ||
			(i_param_source_sel == `GDSC_PSRC_D); // R05
		code_next = code_reg;
		done_next = i_start;
		if (i_start)
		begin
			// The parameter stands in for the setpoint as the computation input.
			code_next = use_param ? i_param : i_setpoint; // R07
		end
	end

	// Register the result.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			code_reg <= `GDSC_CODE_RST;
			done_reg <= 1'b0;
		end
		else
		begin
			code_reg <= code_next;
			done_reg <= done_next;
		end
	end

	assign o_code = code_reg;
	assign o_done = done_reg; // R22

endmodule

// >>> src/gdsc_regs.sv
// Purpose: Write-only setpoint, parameter, DAC and calibration registers.
// Assumes: Host writes arrive as one-cycle command strobes with data.
// Notes:   Software configuration and load-DAC bits arrive as plain inputs.
`timescale 1ns/10ps
`include "gdsc_cfg.svh"

// Function
// R01: Setpoint write starts that channel's code computation.
// R02: Load mode picks input only, or both.
// R03: Setpoint commands are 40h and 42h.
// R04: Use data bits 11..0; setpoints reset zero.
// R05: Parameter feeds computation for sources 2,5,6,7.
// R06: Parameter commands are 44h and 46h.
// R07: Parameter replaces setpoint as the computation input.
// R08: Input write stores code, output stays unchanged.
// R09: Load-DAC bit copies input to output.
// R10: Input commands are 48h and 4Ch.
// R11: Direct write loads input and output together.
// R12: Direct commands are 4Ah and 4Eh.
// R13: Host-written code overrides a computed code; a result landing one cycle after a host write still overwrites the input.
// R14: Bit 4 shorts channel 2 sense inputs.
// R15: Bit 3 shorts channel 1 sense inputs.
// R16: Bit 2 selects acquisition or tracking mode.
// R17: Bit 1 starts calibration, cleared when finished.
// R18: Commanded run with periodic rearms 13 ms wait.
// R19: Bit 0 enables calibration about every 15 ms.
// R20: Calibration control command is 5Eh.
// R21: Acquisition repeats until residual small enough.
// R22: Computation is a separate module with strobe.
module gdsc_regs
#(
	parameter int unsigned P_CAL_PERIOD_CYC =
		`GDSC_CAL_PERIOD_US * 1000 / `GDSC_CLK_PERIOD_NS,
	parameter int unsigned P_CAL_REARM_CYC  =
		`GDSC_CAL_REARM_US * 1000 / `GDSC_CLK_PERIOD_NS
)
(
	// Clock and reset.
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_sys_rst,
	// Host command writes.
	input  wire gdsc_pkg::gdsc_wr_t      i_wr,
	// Software configuration and load-DAC inputs.
	input  wire logic [1:0]              i_load_mode_bits,
	input  wire logic [2:0]              i_ch1_param_source_sel,
	input  wire logic [2:0]              i_ch2_param_source_sel,
	input  wire logic [1:0]              i_load_dac_channel_bit,
	// Calibration engine.
	input  wire logic                    i_cal_done,
	input  wire logic                    i_cal_err_ok,
	output logic                         o_cal_start,
	output logic                         o_cal_busy,
	output gdsc_pkg::gdsc_cal_ctrl_t     o_cal_ctrl,
	// DAC registers.
	output logic [11:0]                  o_ch1_dac_input,
	output logic [11:0]                  o_ch2_dac_input,
	output logic [11:0]                  o_ch1_dac_out,
	output logic [11:0]                  o_ch2_dac_out
);

	localparam logic [20:0] TMR_PERIOD = 21'(P_CAL_PERIOD_CYC - 1);
	localparam logic [20:0] TMR_REARM  = 21'(P_CAL_REARM_CYC - 1);

	logic [11:0] wr_code;            // Low twelve data bits of a write.
	logic [1:0]  hit_sp;             // Setpoint write per channel.
	logic [1:0]  hit_par;            // Parameter write per channel.
	logic [1:0]  hit_in;             // Input register write per channel.
	logic [1:0]  hit_dir;            // Direct write per channel.
	logic        hit_cal;            // Calibration control write.

	logic [11:0] sp_reg  [2];        // Stored setpoints.
	logic [11:0] sp_next [2];
	logic [11:0] par_reg [2];        // Stored parameters.
	logic [11:0] par_next[2];
	logic [11:0] in_reg  [2];        // DAC input registers.
	logic [11:0] in_next [2];
	logic [11:0] out_reg [2];        // DAC output registers.
	logic [11:0] out_next[2];
	logic [1:0]  start_reg;          // Delayed setpoint strobe.
	logic [1:0]  start_next;
	logic [11:0] calc_code[2];       // Computed codes.
	logic [1:0]  calc_done;          // Computation strobes.

	gdsc_pkg::gdsc_cal_ctrl_t  cal_reg;    // Calibration control bits.
	gdsc_pkg::gdsc_cal_ctrl_t  cal_next;
	gdsc_pkg::gdsc_cal_state_t st_reg;     // Sequencer state.
	gdsc_pkg::gdsc_cal_state_t st_next;
	logic        cmd_run_reg;      // Current run was commanded.
	logic        cmd_run_next;
	logic        cstart_reg;       // Start pulse to the engine.
	logic        cstart_next;
	logic [20:0] tmr_reg;          // Periodic calibration countdown.
	logic [20:0] tmr_next;

	// Decode the command byte; data bits 15..12 are ignored.
	always_comb
	begin
		wr_code    = i_wr.data[`GDSC_CODE_MSB:0]; // R04
		hit_sp[0]  = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH1_SETPOINT);
		hit_sp[1]  = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH2_SETPOINT);
		// R03
		hit_par[0] = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH1_PARAM);
		hit_par[1] = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH2_PARAM);
		// R06
		hit_in[0]  = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH1_DAC_INPUT);
		hit_in[1]  = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH2_DAC_INPUT);
		// R10
		hit_dir[0] = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH1_DAC_DIRECT);
		hit_dir[1] = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CH2_DAC_DIRECT);
		// R12
		hit_cal    = i_wr.valid && (i_wr.cmd == `GDSC_CMD_CAL_CTRL); // R20
	end

	// One computation unit per channel works from the stored values.
	gdsc_code_calc u_calc_ch1
	(
		.i_ref_clk          (i_ref_clk),
		.i_sys_rst          (i_sys_rst),
		.i_start            (start_reg[0]),
		.i_setpoint         (sp_reg[0]),
		.i_param            (par_reg[0]),
		.i_param_source_sel (i_ch1_param_source_sel),
		.o_code             (calc_code[0]),
		.o_done             (calc_done[0])
	);

	gdsc_code_calc u_calc_ch2
	(
		.i_ref_clk          (i_ref_clk),
		.i_sys_rst          (i_sys_rst),
		.i_start            (start_reg[1]),
		.i_setpoint         (sp_reg[1]),
		.i_param            (par_reg[1]),
		.i_param_source_sel (i_ch2_param_source_sel),
		.o_code             (calc_code[1]),
		.o_done             (calc_done[1])
	);

	// Channel registers; host writes outrank a computed result landing in the same
	// cycle, but a result landing one cycle after a host write still overwrites the input.
	always_comb
	begin
		for (int ch = 0; ch < 2; ch++)
		begin
			sp_next[ch]    = hit_sp[ch] ? wr_code : sp_reg[ch];
			par_next[ch]   = hit_par[ch] ? wr_code : par_reg[ch];
			start_next[ch] = hit_sp[ch]; // R01
			in_next[ch]    = in_reg[ch];
			out_next[ch]   = out_reg[ch];
			if (hit_dir[ch])
			begin
				in_next[ch]  = wr_code; // R11
				out_next[ch] = wr_code; // R13
			end
			else if (hit_in[ch])
			begin
				in_next[ch]  = wr_code; // R08
				if (i_load_dac_channel_bit[ch])
				begin
					out_next[ch] = in_reg[ch]; // R09
				end
			end
			else
			begin
				if (calc_done[ch])
				begin
					in_next[ch] = calc_code[ch]; // R02
				end
				if (i_load_dac_channel_bit[ch])
				begin
					out_next[ch] = in_reg[ch]; // R09
				end
				else if (calc_done[ch] && i_load_mode_bits[ch])
				begin
					out_next[ch] = calc_code[ch]; // R02
				end
			end
		end
	end

	// Register the channel state.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			for (int ch = 0; ch < 2; ch++)
			begin
				sp_reg[ch]  <= `GDSC_CODE_RST; // R04
				par_reg[ch] <= `GDSC_CODE_RST;
				in_reg[ch]  <= `GDSC_CODE_RST;
				out_reg[ch] <= `GDSC_CODE_RST;
			end
			start_reg <= 2'h0;
		end
		else
		begin
			for (int ch = 0; ch < 2; ch++)
			begin
				sp_reg[ch]  <= sp_next[ch];
				par_reg[ch] <= par_next[ch];
				in_reg[ch]  <= in_next[ch];
				out_reg[ch] <= out_next[ch];
			end
			start_reg <= start_next;
		end
	end

	// Calibration control and sequencer. A one-shot request written in
	// the finishing cycle survives the clear and starts a new routine.
	always_comb
	begin
		cal_next     = cal_reg;
		st_next      = st_reg;
		cmd_run_next = cmd_run_reg;
		cstart_next  = 1'b0;
		tmr_next     = tmr_reg;
		if (hit_cal)
		begin
			cal_next = gdsc_pkg::gdsc_cal_ctrl_t'(i_wr.data[4:0]);
			// R14 R15 R16
		end
		case (st_reg)
			gdsc_pkg::GDSC_CAL_IDLE:
			begin
				if (!cal_reg.cal_periodic_en)
				begin
					tmr_next = TMR_PERIOD;
				end
				else if (tmr_reg != 21'h00_0000)
				begin
					tmr_next = tmr_reg - 21'h00_0001;
				end
				if (cal_reg.cal_oneshot)
				begin
					st_next      = gdsc_pkg::GDSC_CAL_RUN; // R17
					cstart_next  = 1'b1;
					cmd_run_next = 1'b1;
				end
				else if (cal_reg.cal_periodic_en &&
					(tmr_reg == 21'h00_0000))
				begin
					st_next      = gdsc_pkg::GDSC_CAL_RUN; // R19
					cstart_next  = 1'b1;
					cmd_run_next = 1'b0;
				end
			end
			gdsc_pkg::GDSC_CAL_RUN:
			begin
				if (i_cal_done)
				begin
					if (!cal_reg.track && !i_cal_err_ok)
					begin
						cstart_next = 1'b1; // R21
					end
					else
					begin
						st_next  = gdsc_pkg::GDSC_CAL_IDLE;
						tmr_next = cmd_run_reg ? TMR_REARM : TMR_PERIOD;
						// R18
						if (cmd_run_reg &&
							!(hit_cal && i_wr.data[`GDSC_CAL_ONESHOT_BIT]))
						begin
							cal_next.cal_oneshot = 1'b0; // R17
						end
					end
				end
			end
			default:
			begin
				st_next = gdsc_pkg::GDSC_CAL_IDLE;
			end
		endcase
	end

	// Register the calibration state.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			cal_reg     <= gdsc_pkg::gdsc_cal_ctrl_t'(`GDSC_CAL_RST);
			st_reg      <= gdsc_pkg::GDSC_CAL_IDLE;
			cmd_run_reg <= 1'b0;
			cstart_reg  <= 1'b0;
			tmr_reg     <= TMR_PERIOD;
		end
		else
		begin
			cal_reg     <= cal_next;
			st_reg      <= st_next;
			cmd_run_reg <= cmd_run_next;
			cstart_reg  <= cstart_next;
			tmr_reg     <= tmr_next;
		end
	end

	assign o_cal_start     = cstart_reg;
	assign o_cal_busy      = (st_reg == gdsc_pkg::GDSC_CAL_RUN);
	assign o_cal_ctrl      = cal_reg;
	assign o_ch1_dac_input = in_reg[0];
	assign o_ch2_dac_input = in_reg[1];
	assign o_ch1_dac_out   = out_reg[0];
	assign o_ch2_dac_out   = out_reg[1];

	// Checks on the command decode, load paths and calibration sequencer.
	a_sp_store: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit_sp[0] |=> (sp_reg[0] == $past(wr_code))) // R04
		else $error("Setpoint not stored.");
	a_calc_trig: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit_sp[1] |-> ##2 calc_done[1]) // R01
		else $error("Setpoint write gave no computation.");
	a_direct_load: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		hit_dir[0] |=> (o_ch1_dac_out == $past(wr_code)) &&
			(o_ch1_dac_input == $past(wr_code))) // R11
		else $error("Direct write did not load both registers.");
	a_input_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit_in[1] && !i_load_dac_channel_bit[1] |=> $stable(o_ch2_dac_out))
		// R08
		else $error("Input write moved the output.");
	a_load_copy: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_load_dac_channel_bit[0] && !hit_dir[0] |=>
			(o_ch1_dac_out == $past(o_ch1_dac_input))) // R09
		else $error("Load strobe did not copy the input.");
	a_mode_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		calc_done[1] && !hit_dir[1] && !hit_in[1] |=>
			(o_ch2_dac_input == $past(calc_code[1]))) // R02
		else $error("Computed code not placed in input.");
	a_host_wins: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		calc_done[0] && hit_in[0] |=>
			(o_ch1_dac_input == $past(wr_code))) // R13
		else $error("Computed code overrode a host write.");
	a_short_bits: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit_cal |=> (o_cal_ctrl.ch2_offset_short == $past(i_wr.data[4])) &&
			(o_cal_ctrl.ch1_offset_short == $past(i_wr.data[3]))) // R14
		else $error("Offset short bits not taken.");
	a_cal_start: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		hit_cal && i_wr.data[1] && !o_cal_busy |-> ##2 o_cal_start) // R17
		else $error("One-shot write did not start calibration.");
	a_acq_repeat: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_cal_busy && i_cal_done && !o_cal_ctrl.track && !i_cal_err_ok
			|=> o_cal_start && o_cal_busy) // R21
		else $error("Acquisition did not repeat.");
	a_oneshot_clr: assert property (@(posedge i_ref_clk)
		disable iff (i_sys_rst)
		o_cal_busy && cmd_run_reg && i_cal_done &&
			(o_cal_ctrl.track || i_cal_err_ok) && !hit_cal
			|=> !o_cal_ctrl.cal_oneshot && !o_cal_busy) // R17
		else $error("One-shot bit not cleared at end.");

endmodule

// >>> bench/gdsc_cal_engine_model.sv
// Purpose: Behavioural calibration engine that answers start pulses.
// Assumes: Start is a one-cycle pulse; done is given only while busy.
// Notes:   Slow mode stretches a pass so that busy stays up longer.
`timescale 1ns/10ps
module gdsc_cal_engine_model
(
	// Clock and bench controls.
	input  wire logic i_ref_clk,
	input  wire logic i_cal_start,
	input  wire logic i_slow,
	input  wire logic i_converge,
	// Answers to the bank.
	output logic      o_cal_done,
	output logic      o_cal_err_ok,
	output int        o_starts
);
	int cnt; // Cycles left in the running pass.
	initial
	begin
		o_cal_done   = 1'b0;
		o_cal_err_ok = 1'b0;
		o_starts     = 0;
		cnt          = 0;
	end
	// The residual flag only means something beside done, so it shows
	// the opposite level elsewhere to expose a careless sampler.
	always @(posedge i_ref_clk)
	begin
		o_cal_done   <= 1'b0;
		o_cal_err_ok <= ~i_converge;
		if (i_cal_start)
		begin
			o_starts <= o_starts + 1;
			cnt      <= i_slow ? 6 : 2;
		end
		else if (cnt == 1)
		begin
			o_cal_done   <= 1'b1;
			o_cal_err_ok <= i_converge;
			cnt          <= 0;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule

// >>> bench/gdsc_regs_tb.sv
// Purpose: Self-checking bench for the setpoint and calibration bank.
// Assumes: Inputs change on the falling edge; short timer counts.
// Notes:   Expected codes are kept in the bench, never read back.
`timescale 1ns/10ps
`include "gdsc_cfg.svh"
module gdsc_regs_tb;
	localparam int unsigned PER = 20; // Shortened periodic interval.
	localparam int unsigned RAR = 12; // Shortened rearm interval.
	logic               i_ref_clk, i_sys_rst, slow, converge;
	gdsc_pkg::gdsc_wr_t i_wr;
	logic [1:0]         lmode, ldac;
	logic [2:0]         src1, src2;
	logic               done, errok, start, busy;
	gdsc_pkg::gdsc_cal_ctrl_t ctrl;
	logic [11:0]        in1, in2, out1, out2, code;
	logic [11:0]        ei [2]; // Expected input registers.
	logic [11:0]        eo [2]; // Expected output registers.
	logic [15:0]        d, k;
	int                 starts, st0, n, it, ch, bad_count, n_tests, cyc;
	logic [7:0]         c_sp [2] = '{`GDSC_CMD_CH1_SETPOINT,
		`GDSC_CMD_CH2_SETPOINT};
	logic [7:0]         c_pa [2] = '{`GDSC_CMD_CH1_PARAM,
		`GDSC_CMD_CH2_PARAM};
	logic [7:0]         c_in [2] = '{`GDSC_CMD_CH1_DAC_INPUT,
		`GDSC_CMD_CH2_DAC_INPUT};
	logic [7:0]         c_di [2] = '{`GDSC_CMD_CH1_DAC_DIRECT,
		`GDSC_CMD_CH2_DAC_DIRECT};

	gdsc_regs #(.P_CAL_PERIOD_CYC(PER), .P_CAL_REARM_CYC(RAR)) DUT (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr),
		.i_load_mode_bits(lmode), .i_ch1_param_source_sel(src1),
		.i_ch2_param_source_sel(src2), .i_load_dac_channel_bit(ldac),
		.i_cal_done(done), .i_cal_err_ok(errok), .o_cal_start(start),
		.o_cal_busy(busy), .o_cal_ctrl(ctrl), .o_ch1_dac_input(in1),
		.o_ch2_dac_input(in2), .o_ch1_dac_out(out1), .o_ch2_dac_out(out2));
	gdsc_cal_engine_model eng (
		.i_ref_clk(i_ref_clk), .i_cal_start(start), .i_slow(slow),
		.i_converge(converge), .o_cal_done(done), .o_cal_err_ok(errok),
		.o_starts(starts));

	// Clock at 125 MHz.
	initial
	begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	// A hang is cut short well beyond the expected run length.
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Compares one 12-bit result with its expectation.
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Presents one command for one edge; valid is left up for chaining.
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		i_wr = '{1'b1, c, v};
		@(negedge i_ref_clk);
	endtask
	task automatic idle(input int m);
		i_wr.valid = 1'b0;
		repeat (m) @(negedge i_ref_clk);
	endtask
	task automatic check_all();
		chk(in1, ei[0]);
		chk(in2, ei[1]);
		chk(out1, eo[0]);
		chk(out2, eo[1]);
	endtask
	// The parameter replaces the setpoint only for four source codes.
	function automatic logic [11:0] calc(input logic [2:0] s,
		input logic [11:0] sp, input logic [11:0] pa);
		return (s inside {3'h2, 3'h5, 3'h6, 3'h7}) ? pa : sp;
	endfunction
	// Waits for busy to rise and then fall, then counts idle cycles to the next start.
	task automatic gap(output int g);
		for (g = 0; g < 200 && busy !== 1'b1; g++) @(negedge i_ref_clk);
		for (g = 0; g < 200 && busy !== 1'b0; g++) @(negedge i_ref_clk);
		for (g = 0; g < 200 && start !== 1'b1; g++) @(negedge i_ref_clk);
	endtask
	// A oneshot pass with the given mode; returns how many passes ran.
	task automatic oneshot(input logic [15:0] v, output int p);
		st0 = starts;
		wr(`GDSC_CMD_CAL_CTRL, v);
		idle(1);
		for (n = 0; n < 200 && starts < st0 + 2 && busy !== 1'b0; n++)
			@(negedge i_ref_clk);
		converge = 1'b1;
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge i_ref_clk);
		idle(1);
		p = starts - st0;
	endtask

	initial
	begin
		void'($urandom(32'hb1e2a288));
		{i_sys_rst, slow, converge, lmode, ldac, src1, src2} = '0;
		i_sys_rst = 1'b1;
		i_wr = '0;
		{bad_count, n_tests, cyc} = '0;
		ei = '{12'h0, 12'h0};
		eo = '{12'h0, 12'h0};
		repeat (6) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		check_all();
		chk({7'h0, ctrl}, 12'h000);
		// Random mix of host writes, loads and computations.
		for (it = 0; it < 60; it++)
		begin
			ch = $urandom % 2;
			d = $urandom;
			k = $urandom;
			case ($urandom % 5)
				0:
				begin
					wr(c_in[ch], d);
					ei[ch] = d[11:0];
				end
				1:
				begin
					wr(c_di[ch], d);
					ei[ch] = d[11:0];
					eo[ch] = d[11:0];
				end
				2:
				begin
					ldac = 2'(1 << ch);
					@(negedge i_ref_clk);
					ldac = 2'b00;
					eo[ch] = ei[ch];
				end
				3:
				begin
					lmode = $urandom;
					{src1, src2} = $urandom;
					wr(c_pa[ch], k);
					wr(c_sp[ch], d);
					idle(1);
					code = calc(ch ? src2 : src1, d[11:0], k[11:0]);
					ei[ch] = code;
					if (lmode[ch])
						eo[ch] = code;
				end
				default: wr(8'h50 | 8'($urandom % 8), d);
			endcase
			idle(1);
			check_all();
		end
		// A direct write in the cycle the computation lands wins.
		lmode = 2'b11;
		wr(c_sp[0], 16'hfabc);
		idle(1);
		wr(c_di[0], 16'h0123);
		idle(3);
		ei[0] = 12'h123;
		eo[0] = 12'h123;
		check_all();
		// Every combination of the short and mode bits reads back.
		for (it = 0; it < 8; it++)
		begin
			d = $urandom;
			wr(`GDSC_CMD_CAL_CTRL, {d[15:5], 3'(it), 2'b00});
			idle(1);
			chk({7'h0, ctrl}, {7'h0, 3'(it), 2'b00});
		end
		// Acquisition repeats until the residual is small enough.
		slow = 1'b1;
		oneshot(16'h0002, n);
		chk(12'(n), 12'h002);
		chk({7'h0, ctrl}, 12'h000);
		// Tracking mode runs one pass only.
		converge = 1'b0;
		slow = 1'b0;
		oneshot(16'h0006, n);
		chk(12'(n), 12'h001);
		chk({7'h0, ctrl}, 12'h004);
		// Periodic passes keep the full interval between them.
		wr(`GDSC_CMD_CAL_CTRL, 16'h0001);
		idle(1);
		gap(n);
		chk(12'(n >= PER - 2 && n <= PER + 1), 12'h001);
		// A commanded pass with periodic on rearms the shorter wait.
		// Write it while idle so that it does not queue behind the timed pass.
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge i_ref_clk);
		wr(`GDSC_CMD_CAL_CTRL, 16'h0003);
		idle(1);
		gap(n);
		chk(12'(n >= RAR - 2 && n <= RAR + 1), 12'h001);
		wr(`GDSC_CMD_CAL_CTRL, 16'h0000);
		idle(40);
		complete_run();
	end
endmodule
